// *** rtl/nbl_pkg.sv ***
package nbl_pkg;

	// apb byte addresses
	localparam logic [11:0] ADDR_PROT = 12'h000;
	localparam logic [11:0] ADDR_CFG = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_CMD = 12'h00c;
	localparam logic [11:0] ADDR_LOCKED = 12'h010;
	localparam logic [11:0] ADDR_PAR_LO = 12'h014;
	localparam logic [11:0] ADDR_PAR_HI = 12'h018;

	// protection register fields
	localparam int PROT_RS_LSB = 0;
	localparam int PROT_INV_BIT = 3;
	localparam int PROT_CMP_BIT = 4;
	localparam int PROT_LWD_BIT = 5;
	localparam logic [2:0] RS_RESET = 3'h7;
	localparam logic [2:0] RS_NONE = 3'h0;
	localparam logic [2:0] RS_ALL = 3'h7;
	localparam logic [2:0] RS_BLOCK0 = 3'h6;

	// configuration register fields
	localparam int CFG_QE_BIT = 0;
	localparam int CFG_ECC_BIT = 4;
	localparam int CFG_FREEZE_BIT = 6;

	// status register fields
	localparam int ST_OIP_BIT = 0;
	localparam int ST_EFAIL_BIT = 2;
	localparam int ST_PFAIL_BIT = 3;
	localparam int ST_CS_LSB = 4;
	localparam int ST_CNT_LSB = 6;
	localparam logic [1:0] CS_CLEAN = 2'h0;
	localparam logic [1:0] CS_FIXED = 2'h1;
	localparam logic [1:0] CS_UNCORR = 2'h2;

	// command register fields and opcodes
	localparam int CMD_OP_LSB = 16;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_RESET = 2'h3;

	// row decode
	localparam logic [16:0] LOCK_UNIT = 17'h00200;
	localparam logic [16:0] ROW_SPAN = 17'h10000;
	localparam logic [15:0] BLOCK0_LAST_ROW = 16'h003f;

	// page layout
	localparam logic [11:0] SPARE_BASE = 12'h800;
	localparam logic [11:0] PARITY_BASE = 12'h840;
	localparam logic [3:0] META_I_BYTES = 4'h4;
	localparam logic [9:0] MAIN_SEG_BYTES = 10'h200;
	localparam logic [9:0] SEG_LAST_IDX = 10'h20b;
	localparam int SEGS = 4;

	// busy time in sampled link clock rising edges
	localparam logic [7:0] BUSY_LINK_EDGES = 8'h08;

	typedef struct packed {
		logic valid;
		logic first;
		logic [11:0] addr;
		logic [7:0] data;
	} nbl_cache_type;

	typedef logic [13:0] nbl_code_type;
	typedef nbl_code_type [3:0] nbl_codes_type;

	typedef struct packed {
		logic valid;
		logic [11:0] addr;
		logic [2:0] bitpos;
	} nbl_fix_type;
	typedef nbl_fix_type [3:0] nbl_fixes_type;

endpackage

// *** rtl/nbl_sync3.sv ***
`timescale 1ns/1ps
module nbl_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic async_in,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	// a change counts only once stages two and three agree
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			level_q <= RESET_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign level = level_q;
endmodule

// *** rtl/nbl_ecc_acc.sv ***
`timescale 1ns/1ps
module nbl_ecc_acc (
	input wire logic clk,
	input wire logic srst,
	input wire logic first,
	input wire logic en,
	input wire logic [9:0] idx,
	input wire logic [7:0] data,
	output nbl_pkg::nbl_code_type code
);
	// code = {xor of positions of all set bits, overall parity}
	logic [2:0] lo_pos;
	logic par;
	nbl_pkg::nbl_code_type contrib;
	nbl_pkg::nbl_code_type acc_q;
	nbl_pkg::nbl_code_type acc_d;

	always_comb begin
		lo_pos = 3'h0;
		for (int b = 0; b < 8; b++) begin
			if (data[b]) begin
				lo_pos = lo_pos ^ 3'(b);
			end
		end
	end

	assign par = ^data;
	assign contrib = {(par ? idx : 10'h000), lo_pos, par};
	assign acc_d = (first ? 14'h0000 : acc_q) ^ (en ? contrib : 14'h0000);

	always_ff @(posedge clk) begin
		if (srst) begin
			acc_q <= 14'h0000;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign code = acc_q;
endmodule

// *** rtl/nbl_lock_ecc.sv ***
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - reset: range bits all ones, invert, complement, write-disable cleared
// - write-disable set with write-protect low refuses protection changes
// - program or erase to locked row never starts, busy stays 0
// - erase to locked row sets erase fail flag
// - program to locked row sets program fail flag
// - write-protect pin acts only while quad enable is 0
// - codes 0/7 none/all; others lock upper or lower power-of-two sizes
// - complement inverts range of codes 1 to 5 only (0/7 stay none/all); code 6 with complement locks block 0
// - freeze bit clears only on reset; protection bits frozen until reset
// - ecc enabled after power-up
// - ecc enable bit written one turns ecc on, zero off
// - program with ecc computes code over cached page first
// - read recomputes code, compares, reports corrections for the cache on FIX_OUT
// - correction status 00 clean, 01 fixed with count, 10 uncorrectable
// - first four meta bytes of each spare segment are not covered
// - with ecc on host writes into parity region are dropped
// - page is four 512B main segments and 64B spare in four parts
// - program fail clears at program start, erase fail at erase start, both on reset
module nbl_lock_ecc (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic WP_N,
	input wire logic LINK_CLK,
	input wire nbl_pkg::nbl_cache_type CACHE_IN,
	output logic CACHE_WR_OK,
	input wire nbl_pkg::nbl_codes_type CODE_IN,
	output nbl_pkg::nbl_codes_type PARITY_OUT,
	output nbl_pkg::nbl_fixes_type FIX_OUT,
	output logic ARRAY_START,
	output logic [1:0] ARRAY_OP,
	output logic [15:0] ARRAY_ROW,
	output logic BUSY
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} nbl_state_type;

	nbl_state_type state_q;
	nbl_state_type state_d;

	logic [2:0] rs_q;
	logic inv_q;
	logic cmp_q;
	logic lwd_q;
	logic qe_q;
	logic ecc_q;
	logic freeze_q;
	logic efail_q;
	logic pfail_q;
	logic [1:0] cs_q;
	logic [1:0] cnt_q;
	logic [1:0] op_q;
	logic [15:0] row_q;
	logic [7:0] edges_q;
	logic link_prev_q;
	logic start_q;
	logic [31:0] prdata_q;
	nbl_pkg::nbl_codes_type parity_q;
	nbl_pkg::nbl_fixes_type fix_q;

	// pin inputs
	logic wp_n_s;
	logic link_s;

	nbl_sync3 #(.RESET_VAL(1'b1)) u_sync_wp (
		.clk(CORE_CLK),
		.srst(SRST),
		.async_in(WP_N),
		.level(wp_n_s)
	);

	nbl_sync3 #(.RESET_VAL(1'b0)) u_sync_link (
		.clk(CORE_CLK),
		.srst(SRST),
		.async_in(LINK_CLK),
		.level(link_s)
	);

	wire link_rise = link_s & ~link_prev_q;

	// apb decode
	wire apb_setup = PSEL & ~PENABLE;
	wire apb_access = PSEL & PENABLE;
	wire sel_prot = PADDR == nbl_pkg::ADDR_PROT;
	wire sel_cfg = PADDR == nbl_pkg::ADDR_CFG;
	wire sel_status = PADDR == nbl_pkg::ADDR_STATUS;
	wire sel_cmd = PADDR == nbl_pkg::ADDR_CMD;
	wire sel_locked = PADDR == nbl_pkg::ADDR_LOCKED;
	wire sel_par_lo = PADDR == nbl_pkg::ADDR_PAR_LO;
	wire sel_par_hi = PADDR == nbl_pkg::ADDR_PAR_HI;
	wire sel_any = sel_prot | sel_cfg | sel_status | sel_cmd | sel_locked | sel_par_lo |
		sel_par_hi;
	wire wr_en = apb_access & PWRITE & sel_any;

	// write-protect pin only counts while quad mode is off
	wire wp_active = ~wp_n_s & ~qe_q;
	wire prot_wr_ok = ~freeze_q & ~(lwd_q & wp_active);
	wire prot_wr = wr_en & sel_prot & prot_wr_ok;
	wire cfg_wr = wr_en & sel_cfg;
	wire cmd_wr = wr_en & sel_cmd & (state_q == ST_IDLE);

	wire [1:0] cmd_op = PWDATA[nbl_pkg::CMD_OP_LSB +: 2];
	wire [15:0] cmd_row = PWDATA[15:0];

	// locked range decode against the requested row
	wire [16:0] lock_size = nbl_pkg::LOCK_UNIT << rs_q;
	wire [16:0] row17 = {1'b0, cmd_row};
	wire in_upper = row17 >= (nbl_pkg::ROW_SPAN - lock_size);
	wire in_lower = row17 < lock_size;
	wire in_blk0 = cmd_row <= nbl_pkg::BLOCK0_LAST_ROW;
	wire plain_hit = inv_q ? in_lower : in_upper;
	wire cmp_hit = (rs_q == nbl_pkg::RS_BLOCK0) ? in_blk0 : ~plain_hit;
	wire row_locked = (rs_q == nbl_pkg::RS_ALL) |
		((rs_q != nbl_pkg::RS_NONE) & (cmp_q ? cmp_hit : plain_hit));

	wire is_prog = cmd_wr & (cmd_op == nbl_pkg::OP_PROGRAM);
	wire is_erase = cmd_wr & (cmd_op == nbl_pkg::OP_ERASE);
	wire is_reset = cmd_wr & (cmd_op == nbl_pkg::OP_RESET);
	wire is_read = cmd_wr & (cmd_op == nbl_pkg::OP_READ);
	wire refused = (is_prog | is_erase) & row_locked;
	wire go = cmd_wr & ~refused;
	wire busy_done = (state_q == ST_BUSY) & link_rise & (edges_q == nbl_pkg::BUSY_LINK_EDGES);
	wire read_done = busy_done & (op_q == nbl_pkg::OP_READ);

	// cache stream: segment and index of each byte
	wire in_main = CACHE_IN.addr < nbl_pkg::SPARE_BASE;
	wire in_parity = CACHE_IN.addr >= nbl_pkg::PARITY_BASE;
	wire [1:0] cur_seg = in_main ? CACHE_IN.addr[10:9] : CACHE_IN.addr[5:4];
	wire [3:0] meta_off = CACHE_IN.addr[3:0];
	wire meta_covered = meta_off >= nbl_pkg::META_I_BYTES;
	wire covered = CACHE_IN.valid & ~in_parity & (in_main | meta_covered);
	wire [9:0] cur_idx = in_main ? {1'b0, CACHE_IN.addr[8:0]} :
		(nbl_pkg::MAIN_SEG_BYTES + {6'h00, meta_off - nbl_pkg::META_I_BYTES});

	// parity bytes from the host are dropped while ecc is on
	assign CACHE_WR_OK = CACHE_IN.valid & ~(ecc_q & in_parity);

	// one code accumulator per segment, with syndrome analysis
	nbl_pkg::nbl_codes_type acc;
	logic [3:0] seg_fix;
	logic [3:0] seg_bad;
	nbl_pkg::nbl_fixes_type fix_d;

	genvar g;
	generate
		for (g = 0; g < nbl_pkg::SEGS; g++) begin : g_seg
			wire [13:0] syn;
			wire [9:0] bad_idx;
			wire idx_ok;
			wire [11:0] main_addr;
			wire [11:0] meta_addr;

			nbl_ecc_acc u_acc (
				.clk(CORE_CLK),
				.srst(SRST),
				.first(CACHE_IN.valid & CACHE_IN.first),
				.en(covered & (cur_seg == 2'(g))),
				.idx(cur_idx),
				.data(CACHE_IN.data),
				.code(acc[g])
			);

			// odd parity with index in range: one flipped bit at the syndrome position; even but nonzero, or index past the end: more
			assign syn = acc[g] ^ CODE_IN[g];
			assign bad_idx = syn[13:4];
			assign idx_ok = bad_idx <= nbl_pkg::SEG_LAST_IDX;
			assign seg_fix[g] = syn[0] & idx_ok;
			assign seg_bad[g] = (~syn[0] & (syn != 14'h0000)) | (syn[0] & ~idx_ok);
			assign main_addr = {2'(g), bad_idx[8:0], 1'b0} >> 1;
			assign meta_addr = nbl_pkg::SPARE_BASE + {6'h00, 2'(g), 4'h0} +
				{8'h00, nbl_pkg::META_I_BYTES} + {2'h0, bad_idx - nbl_pkg::MAIN_SEG_BYTES};
			assign fix_d[g].valid = seg_fix[g];
			assign fix_d[g].addr = (bad_idx < nbl_pkg::MAIN_SEG_BYTES) ? main_addr : meta_addr;
			assign fix_d[g].bitpos = syn[3:1];
		end
	endgenerate

	wire [2:0] fix_count = {2'h0, seg_fix[0]} + {2'h0, seg_fix[1]} + {2'h0, seg_fix[2]} +
		{2'h0, seg_fix[3]};
	wire any_bad = |seg_bad;
	wire [1:0] cs_new = ~ecc_q ? nbl_pkg::CS_CLEAN : any_bad ? nbl_pkg::CS_UNCORR :
		(fix_count != 3'h0) ? nbl_pkg::CS_FIXED : nbl_pkg::CS_CLEAN;
	wire [1:0] cnt_new = (cs_new == nbl_pkg::CS_FIXED) ? 2'(fix_count - 3'h1) : 2'h0;

	// state machine
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (go) begin
					state_d = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (busy_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// read mux, sampled in the setup phase so the access phase needs no wait
	wire [31:0] rd_prot = {26'h0, lwd_q, cmp_q, inv_q, rs_q};
	wire [31:0] rd_cfg = {25'h0, freeze_q, 1'b0, ecc_q, 3'h0, qe_q};
	wire [31:0] rd_status = {24'h0, cnt_q, cs_q, pfail_q, efail_q, 1'b0,
		state_q == ST_BUSY};
	wire [31:0] rd_cmd = {14'h0, op_q, row_q};
	wire [31:0] rd_par_lo = {4'h0, parity_q[1], parity_q[0]};
	wire [31:0] rd_par_hi = {4'h0, parity_q[3], parity_q[2]};
	wire [31:0] rd_mux = sel_prot ? rd_prot : sel_cfg ? rd_cfg : sel_status ? rd_status :
		sel_cmd ? rd_cmd : sel_locked ? {31'h0, row_locked} : sel_par_lo ? rd_par_lo :
		sel_par_hi ? rd_par_hi : 32'h0;

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state_q <= ST_IDLE;
			prdata_q <= 32'h0;
			link_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			link_prev_q <= link_s;
			if (apb_setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// protection and configuration bits
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rs_q <= nbl_pkg::RS_RESET;
			inv_q <= 1'b0;
			cmp_q <= 1'b0;
			lwd_q <= 1'b0;
			qe_q <= 1'b0;
			ecc_q <= 1'b1;
			freeze_q <= 1'b0;
		end else begin
			if (prot_wr) begin
				rs_q <= PWDATA[nbl_pkg::PROT_RS_LSB +: 3];
				inv_q <= PWDATA[nbl_pkg::PROT_INV_BIT];
				cmp_q <= PWDATA[nbl_pkg::PROT_CMP_BIT];
				lwd_q <= PWDATA[nbl_pkg::PROT_LWD_BIT];
			end
			if (cfg_wr) begin
				qe_q <= PWDATA[nbl_pkg::CFG_QE_BIT];
				ecc_q <= PWDATA[nbl_pkg::CFG_ECC_BIT];
				freeze_q <= freeze_q | PWDATA[nbl_pkg::CFG_FREEZE_BIT];
			end
		end
	end

	// fail flags: a refusal sets the flag in the same write that clears it
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pfail_q <= 1'b0;
			efail_q <= 1'b0;
		end else begin
			if (is_prog) begin
				pfail_q <= row_locked;
			end else if (is_reset) begin
				pfail_q <= 1'b0;
			end
			if (is_erase) begin
				efail_q <= row_locked;
			end else if (is_reset) begin
				efail_q <= 1'b0;
			end
		end
	end

	// operation tracking; busy length counted in link clock edges
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			op_q <= nbl_pkg::OP_READ;
			row_q <= 16'h0;
			edges_q <= 8'h0;
			start_q <= 1'b0;
		end else begin
			start_q <= go & ~is_reset;
			if (go) begin
				op_q <= cmd_op;
				row_q <= cmd_row;
				edges_q <= 8'h1;
			end else if ((state_q == ST_BUSY) & link_rise) begin
				edges_q <= edges_q + 8'h1;
			end
		end
	end

	// ecc results: parity latched at program start, status at read end
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			parity_q <= '0;
			fix_q <= '0;
			cs_q <= nbl_pkg::CS_CLEAN;
			cnt_q <= 2'h0;
		end else begin
			if (is_prog & go & ecc_q) begin
				parity_q <= acc;
			end
			if (read_done) begin
				cs_q <= cs_new;
				cnt_q <= cnt_new;
				fix_q <= (ecc_q & ~any_bad) ? fix_d : '0;
			end else if (go) begin
				fix_q <= '0;
			end
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = 1'b1;
	assign PSLVERR = apb_access & ~sel_any;
	assign PARITY_OUT = parity_q;
	assign FIX_OUT = fix_q;
	assign ARRAY_START = start_q;
	assign ARRAY_OP = op_q;
	assign ARRAY_ROW = row_q;
	assign BUSY = state_q == ST_BUSY;

endmodule

// *** testbench/nbl_lock_ecc_props.sv ***
`timescale 1ns/1ps
module nbl_lock_ecc_props (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire nbl_pkg::nbl_cache_type CACHE_IN,
	input wire logic CACHE_WR_OK,
	input wire logic ARRAY_START,
	input wire logic [1:0] ARRAY_OP,
	input wire logic [15:0] ARRAY_ROW,
	input wire logic BUSY
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	wire rd = PSEL && PENABLE && !PWRITE;
	wire wr = PSEL && PENABLE && PWRITE;
	wire cmd_wr = wr && PADDR == nbl_pkg::ADDR_CMD;
	wire cfg_wr = wr && PADDR == nbl_pkg::ADDR_CFG;
	wire st_rd = rd && PADDR == nbl_pkg::ADDR_STATUS;
	wire cfg_rd = rd && PADDR == nbl_pkg::ADDR_CFG;
	logic prot_seen_q, cfg_seen_q, frozen_q, cmd_q;
	// helpers remember whether software has touched a register since reset; cmd_q only marks a command write one cycle back
	wire prot_seen_d = prot_seen_q || (wr && PADDR == nbl_pkg::ADDR_PROT);
	wire cfg_seen_d = cfg_seen_q || cfg_wr;
	wire frozen_d = frozen_q || (cfg_wr && PWDATA[nbl_pkg::CFG_FREEZE_BIT]);
	always_ff @(posedge CORE_CLK) begin
		prot_seen_q <= prot_seen_d && !SRST;
		cfg_seen_q <= cfg_seen_d && !SRST;
		frozen_q <= frozen_d && !SRST;
		cmd_q <= cmd_wr && !SRST;
	end
	sequence s_read_cmd;
		cmd_wr && !BUSY && PWDATA[17:16] == nbl_pkg::OP_READ;
	endsequence
	sequence s_started;
		ARRAY_START && BUSY;
	endsequence
	property p_prot_reset;
		rd && PADDR == nbl_pkg::ADDR_PROT && !prot_seen_q |-> PRDATA[5:0] == 6'h07;
	endproperty
	property p_ecc_reset;
		cfg_rd && !cfg_seen_q |->
			PRDATA[nbl_pkg::CFG_ECC_BIT] && !PRDATA[nbl_pkg::CFG_FREEZE_BIT];
	endproperty
	property p_freeze_sticks;
		cfg_rd && frozen_q |-> PRDATA[nbl_pkg::CFG_FREEZE_BIT];
	endproperty
	property p_read_go;
		s_read_cmd |=> s_started ##0
			(ARRAY_OP == nbl_pkg::OP_READ && ARRAY_ROW == $past(PWDATA[15:0]));
	endproperty
	property p_start_cause;
		ARRAY_START |-> cmd_q && ARRAY_OP != nbl_pkg::OP_RESET;
	endproperty
	property p_start_pulse;
		s_started |=> !ARRAY_START && BUSY;
	endproperty
	property p_oip;
		st_rd |-> PRDATA[nbl_pkg::ST_OIP_BIT] == $past(BUSY);
	endproperty
	property p_cs_legal;
		st_rd |-> PRDATA[5:4] != 2'h3;
	endproperty
	property p_wr_ok;
		CACHE_IN.valid && CACHE_IN.addr < nbl_pkg::PARITY_BASE |-> CACHE_WR_OK;
	endproperty
	a_prot_reset: assert property (p_prot_reset)
		else $error("protection not at reset value");
	a_ecc_reset: assert property (p_ecc_reset)
		else $error("ecc not enabled after reset");
	a_freeze_sticks: assert property (p_freeze_sticks)
		else $error("freeze bit cleared");
	a_read_go: assert property (p_read_go)
		else $error("read command not started");
	a_start_cause: assert property (p_start_cause)
		else $error("array start without command");
	a_start_pulse: assert property (p_start_pulse)
		else $error("array start not one pulse");
	a_oip: assert property (p_oip)
		else $error("busy flag differs from busy");
	a_cs_legal: assert property (p_cs_legal)
		else $error("reserved correction status");
	a_wr_ok: assert property (p_wr_ok)
		else $error("cache byte refused outside parity");
endmodule

bind nbl_lock_ecc nbl_lock_ecc_props nbl_lock_ecc_props_i (.CORE_CLK(CORE_CLK), .SRST(SRST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .CACHE_IN(CACHE_IN), .CACHE_WR_OK(CACHE_WR_OK), .ARRAY_START(ARRAY_START),
	.ARRAY_OP(ARRAY_OP), .ARRAY_ROW(ARRAY_ROW), .BUSY(BUSY));

// *** testbench/nbl_link_model.sv ***
`timescale 1ns/1ps
module nbl_link_model (
	input wire logic run,
	output logic link_clk
);
	// stands low between frames; the 3 ns offset keeps edges off the core clock edges
	initial begin
		link_clk = 1'b0;
		#3;
		forever begin
			#160;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end
endmodule

// *** testbench/tb_nbl_lock_ecc.sv ***
`timescale 1ns/1ps
module tb_nbl_lock_ecc;
	logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic wp_n = 1'b1, run = 1'b0, pready, pslverr, wr_ok, start, busy, link_clk;
	logic last_err = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [1:0] op;
	logic [15:0] row;
	nbl_pkg::nbl_cache_type cache = '0;
	nbl_pkg::nbl_codes_type code = '0, par;
	nbl_pkg::nbl_fixes_type fix;
	int failures = 0, cmp_count = 0;
	// {expected lock, protection byte, row}
	localparam logic [27:0] RANGES [14] = '{28'h000ffff, 28'h11f0000, 28'h101fc00, 28'h001fbff,
		28'h1068000, 28'h10903ff, 28'h0090400, 28'h111fbff, 28'h011fc00, 28'h1190400,
		28'h015c000, 28'h116003f, 28'h01e0040, 28'h11d4000};
	always #20 core_clk = ~core_clk;
	nbl_link_model nbl_link_model_i (.run(run), .link_clk(link_clk));
	nbl_lock_ecc nbl_lock_ecc_i (.CORE_CLK(core_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .WP_N(wp_n), .LINK_CLK(link_clk), .CACHE_IN(cache),
		.CACHE_WR_OK(wr_ok), .CODE_IN(code), .PARITY_OUT(par), .FIX_OUT(fix),
		.ARRAY_START(start), .ARRAY_OP(op), .ARRAY_ROW(row), .BUSY(busy));
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a stalled transfer
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, d, r);
		check(n, r, e);
	endtask
	task automatic cmd(input logic [1:0] o, input logic [15:0] rw);
		wr(nbl_pkg::ADDR_CMD, {14'h0, o, rw});
		@(negedge core_clk);
	endtask
	// link clock runs only while an operation is pending
	task automatic idle;
		int i;
		run <= 1'b1;
		for (i = 0; i < 400; i++) begin
			@(posedge core_clk);
			if (busy === 1'b0) break;
		end
		check("busy", busy, 0);
		run <= 1'b0;
	endtask
	task automatic put(input logic f, input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cache <= {1'b1, f, a, d};
	endtask
	task automatic put_end;
		@(posedge core_clk);
		cache <= '0;
	endtask
	task automatic t_reset;
		rd("prot", nbl_pkg::ADDR_PROT, 0, 32'h07);
		check("slverr", last_err, 0);
		rd("cfg", nbl_pkg::ADDR_CFG, 0, 32'h10);
		rd("status", nbl_pkg::ADDR_STATUS, 0, 0);
		rd("unmapped", 12'h01c, 0, 0);
		check("slverr", last_err, 1);
		$display("test reset done");
	endtask
	task automatic t_locked;
		cmd(nbl_pkg::OP_PROGRAM, 16'h1234);
		check("start", start, 0);
		check("busy", busy, 0);
		rd("status", nbl_pkg::ADDR_STATUS, 0, 32'h08);
		cmd(nbl_pkg::OP_ERASE, 16'h0000);
		rd("status", nbl_pkg::ADDR_STATUS, 0, 32'h0c);
		cmd(nbl_pkg::OP_RESET, 16'h0000);
		idle;
		rd("status", nbl_pkg::ADDR_STATUS, 0, 0);
		$display("test locked done");
	endtask
	task automatic t_range;
		for (int i = 0; i < 14; i++) begin
			wr(nbl_pkg::ADDR_PROT, {24'h0, RANGES[i][23:16]});
			rd("locked", nbl_pkg::ADDR_LOCKED, {16'h0, RANGES[i][15:0]},
				{31'h0, RANGES[i][24]});
		end
		cmd(nbl_pkg::OP_ERASE, 16'h3fff);
		check("start", start, 1);
		check("op", op, nbl_pkg::OP_ERASE);
		check("row", row, 16'h3fff);
		idle;
		cmd(nbl_pkg::OP_PROGRAM, 16'h4000);
		check("start", start, 0);
		rd("status", nbl_pkg::ADDR_STATUS, 0, 32'h08);
		$display("test range done");
	endtask
	task automatic t_ecc;
		wr(nbl_pkg::ADDR_PROT, 0);
		put(1'b1, 12'h003, 8'h01);
		put(1'b0, 12'h200, 8'h80);
		put(1'b0, 12'h800, 8'hff);
		@(negedge core_clk);
		check("mark_ok", wr_ok, 1);
		put(1'b0, 12'h804, 8'h04);
		put(1'b0, 12'h840, 8'h55);
		@(negedge core_clk);
		check("wr_ok", wr_ok, 0);
		put_end;
		cmd(nbl_pkg::OP_PROGRAM, 16'h0100);
		check("start", start, 1);
		check("par0", par[0], 14'h2034);
		check("par1", par[1], 14'h000f);
		idle;
		rd("par_lo", nbl_pkg::ADDR_PAR_LO, 0, 32'h0003e034);
		// one flipped bit in each of segments 0 and 1
		code <= {14'h0, 14'h0, 14'h000c, 14'h2063};
		cmd(nbl_pkg::OP_READ, 16'h0100);
		idle;
		rd("status", nbl_pkg::ADDR_STATUS, 0, 32'h50);
		check("fix0", fix[0], {1'b1, 12'h005, 3'h3});
		check("fix1", fix[1], {1'b1, 12'h200, 3'h1});
		code <= {14'h0, 14'h0, 14'h001f, 14'h2034};
		cmd(nbl_pkg::OP_READ, 16'h0100);
		idle;
		rd("status", nbl_pkg::ADDR_STATUS, 0, 32'h20);
		check("fix0", fix[0].valid, 0);
		wr(nbl_pkg::ADDR_CFG, 0);
		put(1'b1, 12'h840, 8'h55);
		@(negedge core_clk);
		check("wr_ok", wr_ok, 1);
		put_end;
		cmd(nbl_pkg::OP_READ, 16'h0100);
		idle;
		rd("status", nbl_pkg::ADDR_STATUS, 0, 0);
		wr(nbl_pkg::ADDR_CFG, 32'h10);
		$display("test ecc done");
	endtask
	task automatic t_wp;
		wr(nbl_pkg::ADDR_PROT, 32'h20);
		wp_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		wr(nbl_pkg::ADDR_PROT, 32'h07);
		rd("prot", nbl_pkg::ADDR_PROT, 0, 32'h20);
		wr(nbl_pkg::ADDR_CFG, 32'h11);
		wr(nbl_pkg::ADDR_PROT, 32'h07);
		rd("prot", nbl_pkg::ADDR_PROT, 0, 32'h07);
		wr(nbl_pkg::ADDR_CFG, 32'h10);
		wp_n <= 1'b1;
		$display("test write protect done");
	endtask
	task automatic t_freeze;
		wr(nbl_pkg::ADDR_CFG, 32'h50);
		wr(nbl_pkg::ADDR_CFG, 32'h10);
		rd("cfg", nbl_pkg::ADDR_CFG, 0, 32'h50);
		wr(nbl_pkg::ADDR_PROT, 0);
		rd("prot", nbl_pkg::ADDR_PROT, 0, 32'h07);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd("cfg", nbl_pkg::ADDR_CFG, 0, 32'h10);
		rd("prot", nbl_pkg::ADDR_PROT, 0, 32'h07);
		$display("test freeze done");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		t_reset;
		t_locked;
		t_range;
		t_ecc;
		t_wp;
		t_freeze;
		final_report;
	end
	// whole run needs under a thousand cycles; 20000 leaves wide margin
	initial begin
		#800000;
		failures++;
		final_report;
	end
endmodule
